// file: src/daa_hook_ramp.sv
// Loop current ramp for on-hook transitions
`timescale 1ns/10ps
`include "daa_line_cfg.svh"
module daa_hook_ramp #(
  parameter logic [15:0] STEP_CYCLES = `RAMP_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Control
  input  wire logic       hook_req,
  input  wire logic [1:0] on_hook_speed,
  // Result
  output logic [7:0]      level
);
  logic [15:0] cnt_ff;
  logic [7:0]  level_ff;
  logic [15:0] step_len;
  wire         step_due = (cnt_ff >= step_len);

  // Slower speeds stretch each step; 00 drops at once
  assign step_len = STEP_CYCLES << on_hook_speed;
  assign level    = level_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff   <= 16'h0000;
      level_ff <= 8'h00;
    end else if (ce) begin
      if (hook_req) begin
        level_ff <= 8'hff;
        cnt_ff   <= 16'h0000;
      end else if (on_hook_speed == 2'b00) begin
        level_ff <= 8'h00;
      end else if (level_ff != 8'h00) begin
        cnt_ff <= step_due ? 16'h0000 : cnt_ff + 16'h0001;
        if (step_due) level_ff <= level_ff - 8'h01;
      end
    end
  end
endmodule

// file: src/daa_line_cfg.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DAA_LINE_CFG_SVH
`define DAA_LINE_CFG_SVH
`define OFS_CTRL_ONE      4'h0
`define OFS_CTRL_FIVE     4'h4
`define OFS_CTRL_SIX      4'h8
`define OFS_STATUS_NINE   4'hc
`define BIT_BILL_EN       7
`define BIT_OHS_HI        6
`define BIT_OHS_LO        5
`define BIT_ACT           4
`define BIT_DCT_HI        3
`define BIT_DCT_LO        2
`define BIT_RZ            1
`define BIT_FJM           3
`define BIT_DIAL          2
`define BIT_FORCED_LOWEST_VOLTAGE_MODE          0
`define BIT_OVL           6
`define BIT_BTD           3
`define BIT_ROV           1
`define RST_CTRL_ONE      8'h00
`define RST_CTRL_FIVE     8'h08
`define RST_CTRL_SIX      8'h00
`define RST_STATUS_NINE   8'h20
`define CLK_HZ            100000000
`define RESTORE_MS        1000
`define RESTORE_CYCLES    ((`CLK_HZ / 1000) * `RESTORE_MS)
`define RAMP_STEP_CYCLES  16'h0100
`endif

// file: src/daa_line_control.sv
// Line-side control and billing tone logic with AXI4-Lite registers
// Summary of operation
// - ACT bit picks 600 ohm or complex
// - Ringer bit enables synthesized ringer impedance
// - Lower mode 1.7 dB, lowest 4 dB attenuation
// - Forced bits in default mode skip attenuation
// - Forced bits ignored outside default mode
// - Hook speed field ramps loop current down
// - Billing detection runs only when enabled
// - Sticky overload sets above 1.1 V peak
// - Sticky billing flag sets on supply droop
// - Billing flag forces 800 ohm dc impedance
// - Normal dc returns within one second
// - Sticky flags hold until written zero
// - Stay off-hook through billing events
// - Live overload follows condition only while billing is enabled, self-clears
// - Dc field encodes 10,11,01,00 modes
`timescale 1ns/10ps
`include "daa_line_cfg.svh"
module daa_line_control #(
  parameter int unsigned RESTORE_CYCLES = `RESTORE_CYCLES
) (
  // Clock, enable, reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [3:0]           s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [3:0]           s_axi_araddr,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // Line-side detector pins, asynchronous
  input  wire logic                 line_over_peak,
  input  wire logic                 supply_droop,
  input  wire logic                 hook_cmd,
  // Line drive
  output daa_line_pkg::line_drive_t line_drive
);
  // Register storage
  logic [7:0] ctrl_one_ff;
  logic [7:0] ctrl_five_ff;
  logic [7:0] ctrl_six_ff;
  logic       rov_ff;
  logic       btd_ff;
  logic       ovl_ff;
  logic [1:0] peak_sync_ff;
  logic [1:0] droop_sync_ff;
  logic [1:0] hook_sync_ff;
  daa_line_pkg::bill_state_t   bt_ff;
  daa_line_pkg::bill_state_t   nxt_bt;
  logic [31:0]                 restore_cnt_ff;
  daa_line_pkg::line_drive_t   drive_ff;
  daa_line_pkg::line_drive_t   nxt_drive;
  logic [7:0]                  ramp_level;

  // AXI state
  logic       aw_held_ff;
  logic       w_held_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic       wstrb0_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  logic       rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;

  function automatic logic known_addr(input logic [3:0] a);
    known_addr = (a == `OFS_CTRL_ONE) || (a == `OFS_CTRL_FIVE) ||
                 (a == `OFS_CTRL_SIX) || (a == `OFS_STATUS_NINE);
  endfunction

  // Write path
  wire aw_take   = s_axi_awvalid && !aw_held_ff && !bvalid_ff;
  wire w_take    = s_axi_wvalid && !w_held_ff && !bvalid_ff;
  wire aw_have   = aw_held_ff || aw_take;
  wire w_have    = w_held_ff || w_take;
  wire wr_fire   = aw_have && w_have && !bvalid_ff;
  wire [3:0]  wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
  wire        wr_be0  = w_held_ff ? wstrb0_ff : s_axi_wstrb[0];
  wire        wr_ok   = known_addr(wr_addr);
  wire        wr_lane = wr_fire && wr_ok && wr_be0;
  wire wr_one    = wr_lane && (wr_addr == `OFS_CTRL_ONE);
  wire wr_five   = wr_lane && (wr_addr == `OFS_CTRL_FIVE);
  wire wr_six    = wr_lane && (wr_addr == `OFS_CTRL_SIX);
  wire wr_nine   = wr_lane && (wr_addr == `OFS_STATUS_NINE);
  // Only a written zero clears a sticky flag
  wire clr_rov   = wr_nine && !wr_data[`BIT_ROV];
  wire clr_btd   = wr_nine && !wr_data[`BIT_BTD];

  // Read path
  wire ar_take   = s_axi_arvalid && !rvalid_ff;
  wire [7:0] status_nine = {1'b0, ovl_ff, 2'b10, btd_ff, 1'b0, rov_ff, 1'b0};
  wire [7:0] rd_byte =
    (s_axi_araddr == `OFS_CTRL_ONE)    ? ctrl_one_ff  :
    (s_axi_araddr == `OFS_CTRL_FIVE)   ? ctrl_five_ff :
    (s_axi_araddr == `OFS_CTRL_SIX)    ? ctrl_six_ff  :
    (s_axi_araddr == `OFS_STATUS_NINE) ? status_nine  : 8'h00;

  // Synchronised detector levels
  wire over_peak = peak_sync_ff[1];
  wire droop     = droop_sync_ff[1];
  wire bill_en   = ctrl_one_ff[`BIT_BILL_EN];
  wire detect_on = bill_en && (bt_ff == daa_line_pkg::BT_ARMED);
  wire set_rov   = detect_on && over_peak;
  wire set_btd   = detect_on && droop;
  wire restore_done = (restore_cnt_ff >= RESTORE_CYCLES - 1);

  // Billing state sequence
  always_comb begin
    nxt_bt = bt_ff;
    unique case (bt_ff)
      daa_line_pkg::BT_IDLE:    if (bill_en) nxt_bt = daa_line_pkg::BT_ARMED;
      daa_line_pkg::BT_ARMED:
        if (set_btd) nxt_bt = daa_line_pkg::BT_HOLD;
        else if (!bill_en) nxt_bt = daa_line_pkg::BT_IDLE;
      daa_line_pkg::BT_HOLD:    if (!bill_en) nxt_bt = daa_line_pkg::BT_RESTORE;
      // Restore waits out the settle time so the loop is not upset
      daa_line_pkg::BT_RESTORE: if (restore_done) nxt_bt = daa_line_pkg::BT_IDLE;
      default:                  nxt_bt = daa_line_pkg::BT_IDLE;
    endcase
  end

  // Line drive decode
  wire [1:0] dc_term_mode     = ctrl_five_ff[`BIT_DCT_HI:`BIT_DCT_LO];
  wire       is_fcc  = (dc_term_mode == daa_line_pkg::DCT_FCC);
  wire       forced_lower_voltage_mode     = is_fcc && ctrl_six_ff[`BIT_FJM];
  wire       forced_lowest_voltage_mode    = is_fcc && ctrl_six_ff[`BIT_FORCED_LOWEST_VOLTAGE_MODE];
  wire [1:0] dct_eff = forced_lowest_voltage_mode ? daa_line_pkg::DCT_LOWEST :
                       forced_lower_voltage_mode  ? daa_line_pkg::DCT_LOWER  : dc_term_mode;
  // Attenuation follows the chosen mode, not the forced one
  wire [1:0] atten   = (dc_term_mode == daa_line_pkg::DCT_LOWER)  ? 2'b01 :
                       (dc_term_mode == daa_line_pkg::DCT_LOWEST) ? 2'b10 : 2'b00;
  wire hold_800      = (bt_ff == daa_line_pkg::BT_HOLD) ||
                       (bt_ff == daa_line_pkg::BT_RESTORE);

  always_comb begin
    nxt_drive                        = '0;
    nxt_drive.ac_term_select         = ctrl_five_ff[`BIT_ACT];
    nxt_drive.ringer_impedance_synth = ctrl_five_ff[`BIT_RZ];
    nxt_drive.dc_term_applied        = dct_eff;
    nxt_drive.tx_atten_sel           = atten;
    nxt_drive.dc_800_ohm             = hold_800;
    nxt_drive.dial_headroom          = ctrl_six_ff[`BIT_DIAL];
    // Billing events never release the hook
    nxt_drive.off_hook               = hook_sync_ff[1];
    nxt_drive.loop_current_level     = ramp_level;
  end

  daa_hook_ramp u_ramp (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .ce            (ce),
    .hook_req      (hook_sync_ff[1]),
    .on_hook_speed (ctrl_five_ff[`BIT_OHS_HI:`BIT_OHS_LO]),
    .level         (ramp_level)
  );

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      peak_sync_ff  <= 2'b00;
      droop_sync_ff <= 2'b00;
      hook_sync_ff  <= 2'b00;
    end else if (ce) begin
      peak_sync_ff  <= {peak_sync_ff[0], line_over_peak};
      droop_sync_ff <= {droop_sync_ff[0], supply_droop};
      hook_sync_ff  <= {hook_sync_ff[0], hook_cmd};
    end
  end

  // Registers and flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_one_ff  <= `RST_CTRL_ONE;
      ctrl_five_ff <= `RST_CTRL_FIVE;
      ctrl_six_ff  <= `RST_CTRL_SIX;
      rov_ff       <= 1'b0;
      btd_ff       <= 1'b0;
      ovl_ff       <= 1'b0;
    end else if (ce) begin
      if (wr_one)  ctrl_one_ff  <= wr_data[7:0];
      if (wr_five) ctrl_five_ff <= wr_data[7:0];
      if (wr_six)  ctrl_six_ff  <= wr_data[7:0];
      // Set wins over a clear in the same cycle
      rov_ff <= set_rov | (rov_ff & ~clr_rov);
      btd_ff <= set_btd | (btd_ff & ~clr_btd);
      // Live flag keeps reporting through the hold so the host can poll it
      ovl_ff <= bill_en && over_peak;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bt_ff          <= daa_line_pkg::BT_IDLE;
      restore_cnt_ff <= 32'h0000_0000;
      drive_ff       <= '0;
    end else if (ce) begin
      bt_ff          <= nxt_bt;
      restore_cnt_ff <= (bt_ff == daa_line_pkg::BT_RESTORE) ?
                        restore_cnt_ff + 32'h0000_0001 : 32'h0000_0000;
      drive_ff       <= nxt_drive;
    end
  end

  // AXI handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h0000_0000;
      wstrb0_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'b00;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= 2'b00;
    end else if (ce) begin
      if (aw_take) awaddr_ff <= s_axi_awaddr;
      if (w_take) begin
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      aw_held_ff <= aw_have && !wr_fire;
      w_held_ff  <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (ar_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= {24'h00_0000, rd_byte};
        rresp_ff  <= known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = aw_take;
  assign s_axi_wready  = w_take;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign line_drive    = drive_ff;
endmodule

// file: src/daa_line_pkg.sv
// Types shared by the line control block
package daa_line_pkg;
  typedef enum logic [1:0] {
    DCT_LOWEST = 2'b00,
    DCT_LOWER  = 2'b01,
    DCT_FCC    = 2'b10,
    DCT_LIMIT  = 2'b11
  } dc_term_mode_t;

  typedef enum logic [3:0] {
    BT_IDLE    = 4'b0001,
    BT_ARMED   = 4'b0010,
    BT_HOLD    = 4'b0100,
    BT_RESTORE = 4'b1000
  } bill_state_t;

  typedef struct packed {
    logic       ac_term_select;
    logic       ringer_impedance_synth;
    logic [1:0] dc_term_applied;
    logic [1:0] tx_atten_sel;
    logic       dc_800_ohm;
    logic       dial_headroom;
    logic       off_hook;
    logic [7:0] loop_current_level;
  } line_drive_t;
endpackage

// file: verification/daa_line_checker_assertions.sv
// Port-level assertions for the line control block
`timescale 1ns/10ps
module daa_line_checker (
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Bus handshake
  input wire logic                      s_axi_bvalid,
  input wire logic                      s_axi_bready,
  input wire logic                      s_axi_arready,
  input wire logic                      s_axi_rvalid,
  input wire logic                      s_axi_rready,
  input wire logic [31:0]               s_axi_rdata,
  // Line side
  input wire logic                      supply_droop,
  input wire logic                      hook_cmd,
  input wire daa_line_pkg::line_drive_t line_drive
);
  logic [7:0] droop_age_ff;
  logic [7:0] nxt_droop_age;
  // Saturating age, so a stale droop can never excuse an 800 ohm switch
  assign nxt_droop_age = supply_droop ? 8'h00 : droop_age_ff + {7'h0, droop_age_ff != 8'hff};
  always_ff @(posedge aclk) begin
    droop_age_ff <= aresetn ? nxt_droop_age : 8'hff;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bvalid_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped early");
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refused: assert property (p_ar_refused) else $error("read taken while pending");
  property p_dc_reset;
    $rose(aresetn) |=> line_drive.dc_term_applied == 2'h2;
  endproperty
  a_dc_reset: assert property (p_dc_reset) else $error("dc mode not default");
  property p_hook_on;
    hook_cmd[*6] |-> line_drive.off_hook && line_drive.loop_current_level == 8'hff;
  endproperty
  a_hook_on: assert property (p_hook_on) else $error("off hook not applied");
  property p_ramp_down;
    (!hook_cmd)[*4] |=> line_drive.loop_current_level <= $past(line_drive.loop_current_level);
  endproperty
  a_ramp_down: assert property (p_ramp_down) else $error("loop current rose");
  property p_dc800_cause;
    $rose(line_drive.dc_800_ohm) |-> droop_age_ff <= 8'h08;
  endproperty
  a_dc800_cause: assert property (p_dc800_cause) else $error("800 ohm without tone");
  property p_lowest_atten;
    line_drive.tx_atten_sel == 2'h2 |-> line_drive.dc_term_applied == 2'h0;
  endproperty
  a_lowest_atten: assert property (p_lowest_atten) else $error("4 dB outside mode");
endmodule
bind daa_line_control daa_line_checker ck (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .supply_droop(supply_droop), .hook_cmd(hook_cmd), .line_drive(line_drive));

// file: verification/daa_line_model.sv
// Line model: billing tones, spikes and pulse dialling
`timescale 1ns/10ps
module daa_line_model #(
  parameter int PULSE_HALF = 5
) (
  // Clock
  input wire logic aclk,
  // Scenario controls
  input wire logic tone_on,
  input wire logic spike_on,
  input wire logic off_hook_req,
  input wire logic dial_on,
  // Detector pins
  output logic     line_over_peak,
  output logic     supply_droop,
  output logic     hook_cmd
);
  int   cnt_ff   = 0;
  logic break_ff = 1'h0;
  // A spike alone mimics a parallel phone or a polarity reversal
  assign line_over_peak = tone_on || spike_on;
  assign supply_droop   = tone_on;
  // Scaled pulse rate: ten per second would cost ten million cycles
  assign hook_cmd       = off_hook_req && !(dial_on && break_ff);
  always_ff @(posedge aclk) begin
    cnt_ff <= (cnt_ff == PULSE_HALF - 1) ? 0 : cnt_ff + 1;
    if (cnt_ff == PULSE_HALF - 1) begin
      break_ff <= !break_ff;
    end
  end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the line control block
`timescale 1ns/10ps
module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic line_over_peak, supply_droop, hook_cmd;
  logic tone_on = 1'h0, spike_on = 1'h0, off_hook_req = 1'h0, dial_on = 1'h0;
  daa_line_pkg::line_drive_t line_drive;
  int n_mismatch = 0, num_checks = 0;
  logic [7:0] rd;
  logic [3:0] ofs [4] = '{4'h0, 4'h4, 4'h8, 4'hc};
  logic [7:0] rst [4] = '{8'h00, 8'h08, 8'h00, 8'h20};
  logic [1:0] att [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
  logic [1:0] app [4] = '{2'h0, 2'h1, 2'h1, 2'h3};
  daa_line_control #(.RESTORE_CYCLES(20)) dut (.*);
  daa_line_model lm (.*);
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_drv(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t line drive got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= {24'h0, d};
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && n < 50);
    s_axi_bready <= 1'h0;
    if (n >= 50) begin
      n_mismatch++;
      $display("BAD %0t write response missing", $time);
    end
    chk_reg({6'h0, s_axi_bresp}, 8'h00);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && n < 50);
    s_axi_rready <= 1'h0;
    if (n >= 50) begin
      n_mismatch++;
      $display("BAD %0t read response missing", $time);
    end
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    rd_reg(a, rd, rs);
    chk_reg(rd, exp);
  endtask
  task automatic pulse_spike;
    spike_on <= 1'h1;
    repeat (4) @(posedge aclk);
    spike_on <= 1'h0;
    repeat (4) @(posedge aclk);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 4; i++) rchk(ofs[i], rst[i]);
    rd_reg(4'h2, rd, rs);
    chk_reg({6'h0, rs}, 8'h02);
    for (int m = 0; m < 4; m++) begin
      wr(4'h4, 8'h12 | (8'(m) << 2));
      wr(4'h8, 8'h08);
      repeat (2) @(posedge aclk);
      chk_drv({6'h0, line_drive.tx_atten_sel}, {6'h0, att[m]});
      chk_drv({6'h0, line_drive.dc_term_applied}, {6'h0, app[m]});
    end
    chk_drv({6'h0, line_drive.ac_term_select, line_drive.ringer_impedance_synth}, 8'h03);
    wr(4'h4, 8'h0a);
    wr(4'h8, 8'h09);
    repeat (2) @(posedge aclk);
    chk_drv({6'h0, line_drive.dc_term_applied, line_drive.ac_term_select}, 8'h00);
    chk_drv({6'h0, line_drive.tx_atten_sel, line_drive.ringer_impedance_synth}, 8'h01);
    wr(4'h8, 8'h00);
    wr(4'h4, 8'h0c);
    // Loop voltage reading assumed low enough here
    wr(4'h8, 8'h04);
    repeat (2) @(posedge aclk);
    chk_drv({7'h0, line_drive.dial_headroom}, 8'h01);
    wr(4'h8, 8'h00);
    wr(4'h4, 8'h08);
    off_hook_req <= 1'h1;
    pulse_spike();
    rchk(4'hc, 8'h20);
    wr(4'h0, 8'h80);
    pulse_spike();
    rchk(4'hc, 8'h22);
    wr(4'hc, 8'hff);
    rchk(4'hc, 8'h22);
    tone_on <= 1'h1;
    repeat (8) @(posedge aclk);
    rchk(4'hc, 8'h6a);
    chk_drv({6'h0, line_drive.dc_800_ohm, line_drive.off_hook}, 8'h03);
    tone_on <= 1'h0;
    repeat (4) @(posedge aclk);
    rchk(4'hc, 8'h2a);
    wr(4'h0, 8'h00);
    chk_drv({7'h0, line_drive.dc_800_ohm}, 8'h01);
    repeat (30) @(posedge aclk);
    chk_drv({7'h0, line_drive.dc_800_ohm}, 8'h00);
    wr(4'hc, 8'h00);
    rchk(4'hc, 8'h20);
    wr(4'h0, 8'h80);
    dial_on <= 1'h1;
    repeat (40) @(posedge aclk);
    dial_on <= 1'h0;
    repeat (8) @(posedge aclk);
    chk_drv(line_drive.loop_current_level, 8'hff);
    off_hook_req <= 1'h0;
    repeat (6) @(posedge aclk);
    chk_drv(line_drive.loop_current_level, 8'h00);
    off_hook_req <= 1'h1;
    wr(4'h4, 8'h28);
    repeat (8) @(posedge aclk);
    off_hook_req <= 1'h0;
    // One step of a slow ramp lands between 513 and 1026 cycles
    repeat (700) @(posedge aclk);
    chk_drv({7'h0, line_drive.loop_current_level inside {8'hfd, 8'hfe}}, 8'h01);
    stop_test();
  end
endmodule
